/* File: verilog/lps_map.svh */
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH
// system clock and serial rates
`define LPS_CLK_HZ        20000000
`define LPS_BAUD_4K8      4800
`define LPS_BAUD_9K6      9600
`define LPS_BAUD_19K2     19200
`define LPS_BAUD_38K4     38400
`define LPS_BAUD_57K6     57600
`define LPS_BAUD_115K2    115200
`define LPS_BAUD_500K     500000
// frame header constants
`define LPS_DEST_BYTE     8'hFF
`define LPS_TYPE_BYTE     8'h47
`define LPS_CODE_CM       16'h0001
`define LPS_CODE_MM       16'h0011
`define LPS_LEN_CM        8'h10
`define LPS_LEN_MM        8'h16
`define LPS_HDR_BYTES     5
`define LPS_FRAME_MAX     29
// field offsets within a frame
`define LPS_OFS_TS        5
`define LPS_OFS_X         9
`define LPS_OFS_Y_CM      11
`define LPS_OFS_Z_CM      13
`define LPS_OFS_FLAGS_CM  15
`define LPS_OFS_Y_MM      13
`define LPS_OFS_Z_MM      17
`define LPS_OFS_FLAGS_MM  21
// flag bit positions
`define LPS_FLG_NOPOS     0
`define LPS_FLG_TSMS      1
`define LPS_FLG_BTN1      2
`define LPS_FLG_UPLOAD    3
`define LPS_FLG_DOWNLOAD  4
`define LPS_FLG_BTN2      5
`define LPS_FLG_OTHER     6
`define LPS_FLG_RSVD      7
// crc and spi
`define LPS_CRC_POLY      16'h8005
`define LPS_CRC_INIT      16'hFFFF
`define LPS_SPI_FILLER    8'h00
`define LPS_SCK_HALF      8'h08
// host register offsets and fields
`define LPS_REG_CTRL      4'h0
`define LPS_REG_SPIDATA   4'h4
`define LPS_REG_STATUS    4'h8
`define LPS_REG_RXDATA    4'hC
`define LPS_CTRL_CS       0
`define LPS_CTRL_BAUD_LO  1
`define LPS_ST_SPIBUSY    0
`define LPS_ST_RXVALID    1
`define LPS_ST_RXERR      2
`endif

/* File: verilog/lps_pkg.sv */
package lps_pkg;
  `include "lps_map.svh"

  typedef enum logic [2:0] {
    LPS_B4K8, LPS_B9K6, LPS_B19K2, LPS_B38K4, LPS_B57K6, LPS_B115K2, LPS_B500K
  } lps_baud_type;

  typedef logic [15:0] lps_div_type;

  // clock cycles per serial bit for each rate
  function automatic lps_div_type lps_baud_div(input lps_baud_type b);
    lps_div_type d;
    d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_500K));
    case (b)
      LPS_B4K8:   d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_4K8));
      LPS_B9K6:   d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_9K6));
      LPS_B19K2:  d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_19K2));
      LPS_B38K4:  d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_38K4));
      LPS_B57K6:  d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_57K6));
      LPS_B115K2: d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_115K2));
      default:    d = 16'((`LPS_CLK_HZ) / (`LPS_BAUD_500K));
    endcase
    return d;
  endfunction
endpackage

/* File: verilog/lps_link_if.sv */
`timescale 1ns/1ps
interface lps_link_if;
  logic serialOutLine;      // async serial, idle high
  logic sharedRxSelectPin;  // serial receive or spi chip select, active low
  logic spiClk;             // spi clock from master
  logic spiMiso;            // spi data from beacon
  logic spiMisoOe;          // beacon drives spiMiso while high

  modport beacon (
    output serialOutLine,
    output spiMiso,
    output spiMisoOe,
    input  sharedRxSelectPin,
    input  spiClk
  );
  modport master (
    input  serialOutLine,
    input  spiMiso,
    input  spiMisoOe,
    output sharedRxSelectPin,
    output spiClk
  );
endinterface

/* File: verilog/lps_beacon.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "lps_map.svh"
module lps_beacon
  import lps_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  lps_link_if.beacon               link,
  input  wire logic                measStrobe,
  input  wire logic                measValid,
  input  wire logic                mmMode,
  input  wire logic [31:0]         timeStamp,
  input  wire logic                tsMillis,
  input  wire logic signed [31:0]  posX,
  input  wire logic signed [31:0]  posY,
  input  wire logic signed [31:0]  posZ,
  input  wire logic                btnFirst,
  input  wire logic                btnSecond,
  input  wire logic                uploadPending,
  input  wire logic                downloadWanted,
  input  wire logic                otherBeacon,
  input  wire logic [7:0]          beaconAddr,
  input  wire logic [11:0]         heading,
  input  wire logic [15:0]         elapsedMs,
  input  wire logic                pinIsCs,
  input  wire lps_pkg::lps_baud_type cfgBaud,
  input  wire logic                cfgBaudWr,
  output logic                     measReady,
  output logic                     spiFramePending
);
  import lps_pkg::*;

  typedef enum {TX_IDLE, TX_CRC, TX_SEND} lps_tx_type;

  lps_tx_type   txState_r;
  lps_baud_type baud_r;
  logic [7:0]   frame_r [0:`LPS_FRAME_MAX-1];
  logic [7:0]   frameNxt [0:`LPS_FRAME_MAX-1];
  logic [4:0]   frameLen_r;
  logic [15:0]  crc_r;
  logic [4:0]   byteIdx_r;
  logic [15:0]  baudCnt_r;
  logic [3:0]   bitCnt_r;
  logic [8:0]   txShift_r;
  logic         txLine_r;
  logic         ready_r;
  logic         pending_r;
  logic [2:0]   csSync_r;
  logic [2:0]   clkSync_r;
  logic         csLvl_r;
  logic         sclkLvl_r;
  logic         csActive_r;
  logic [2:0]   spiBit_r;
  logic [4:0]   spiIdx_r;
  logic         spiFromFrame_r;
  logic [7:0]   spiShift_r;
  logic         misoOe_r;

  // byte-wide crc step, msb of the data first
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb)
        r = r ^ `LPS_CRC_POLY;
    end
    return r;
  endfunction

  wire logic [7:0]  flagsByte = {1'b0, otherBeacon, btnSecond, downloadWanted,
                                 uploadPending, btnFirst, tsMillis, ~measValid};
  wire logic [15:0] orientWord = {4'h0, heading};
  wire logic [4:0]  lenNxt = mmMode ? 5'(`LPS_LEN_MM + `LPS_HDR_BYTES + 2)
                                    : 5'(`LPS_LEN_CM + `LPS_HDR_BYTES + 2);
  wire logic [15:0] baudDiv = lps_baud_div(baud_r);
  wire logic        baudTick = (baudCnt_r == baudDiv - 16'h0001);
  wire logic [4:0]  payEnd = frameLen_r - 5'h02;
  wire logic        latch = measStrobe & ready_r;

  // frame image built from the measurement inputs, low byte first
  always_comb
  begin
    logic [4:0] fo;
    fo = mmMode ? 5'(`LPS_OFS_FLAGS_MM) : 5'(`LPS_OFS_FLAGS_CM);
    for (int i = 0; i < `LPS_FRAME_MAX; i++)
      frameNxt[i] = 8'h00;
    frameNxt[0] = `LPS_DEST_BYTE;
    frameNxt[1] = `LPS_TYPE_BYTE;
    frameNxt[2] = mmMode ? 8'(`LPS_CODE_MM) : 8'(`LPS_CODE_CM);
    frameNxt[3] = mmMode ? 8'(`LPS_CODE_MM >> 8) : 8'(`LPS_CODE_CM >> 8);
    frameNxt[4] = mmMode ? `LPS_LEN_MM : `LPS_LEN_CM;
    for (int k = 0; k < 4; k++)
      frameNxt[`LPS_OFS_TS+k] = timeStamp[8*k +: 8];
    for (int k = 0; k < 4; k++)
    begin
      if (mmMode)
      begin
        frameNxt[`LPS_OFS_X+k] = posX[8*k +: 8];
        frameNxt[`LPS_OFS_Y_MM+k] = posY[8*k +: 8];
        frameNxt[`LPS_OFS_Z_MM+k] = posZ[8*k +: 8];
      end
      else if (k < 2)
      begin
        frameNxt[`LPS_OFS_X+k] = posX[8*k +: 8];
        frameNxt[`LPS_OFS_Y_CM+k] = posY[8*k +: 8];
        frameNxt[`LPS_OFS_Z_CM+k] = posZ[8*k +: 8];
      end
    end
    frameNxt[fo] = flagsByte;
    frameNxt[fo+5'h01] = beaconAddr;
    frameNxt[fo+5'h02] = orientWord[7:0];
    frameNxt[fo+5'h03] = orientWord[15:8];
    frameNxt[fo+5'h04] = elapsedMs[7:0];
    frameNxt[fo+5'h05] = elapsedMs[15:8];
  end

  // rate register, takes effect at once, also in the middle of a frame being sent
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      baud_r <= LPS_B500K;
    else if (cfgBaudWr)
      baud_r <= cfgBaud;
  end

  // frame store: latched on a measurement, crc appended afterwards
  always_ff @(posedge clk_sys)
  begin
    if (latch)
      frame_r <= frameNxt;
    else if (txState_r == TX_CRC && byteIdx_r == payEnd)
    begin
      frame_r[payEnd] <= crc_r[7:0];
      frame_r[payEnd+5'h01] <= crc_r[15:8];
    end
  end

  // frame sequencer: crc pass, then unprompted 8N1 transmission
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      txState_r <= TX_IDLE;
      frameLen_r <= 5'h00;
      crc_r <= `LPS_CRC_INIT;
      byteIdx_r <= 5'h00;
      baudCnt_r <= 16'h0000;
      bitCnt_r <= 4'h0;
      txShift_r <= 9'h1FF;
      txLine_r <= 1'b1;
    end
    else
    begin
      baudCnt_r <= (baudTick || txState_r != TX_SEND) ? 16'h0000 : baudCnt_r + 16'h0001;
      unique case (txState_r)
        TX_IDLE:
          if (latch)
          begin
            frameLen_r <= lenNxt;
            crc_r <= `LPS_CRC_INIT;
            byteIdx_r <= 5'h00;
            txState_r <= TX_CRC;
          end
        TX_CRC:
          if (byteIdx_r == payEnd)
          begin
            byteIdx_r <= 5'h00;
            txShift_r <= {1'b1, frame_r[0]};
            bitCnt_r <= 4'h0;
            txLine_r <= 1'b0;
            txState_r <= TX_SEND;
          end
          else
          begin
            crc_r <= crcStep(crc_r, frame_r[byteIdx_r]);
            byteIdx_r <= byteIdx_r + 5'h01;
          end
        TX_SEND:
          if (baudTick)
          begin
            if (bitCnt_r == 4'h9)
            begin
              if (byteIdx_r == frameLen_r - 5'h01)
              begin
                txState_r <= TX_IDLE;
                txLine_r <= 1'b1;
              end
              else
              begin
                byteIdx_r <= byteIdx_r + 5'h01;
                txShift_r <= {1'b1, frame_r[byteIdx_r+5'h01]};
                bitCnt_r <= 4'h0;
                txLine_r <= 1'b0;
              end
            end
            else
            begin
              txLine_r <= txShift_r[0];
              txShift_r <= {1'b1, txShift_r[8:1]};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
      endcase
    end
  end

  // pin synchronisers, a level counts once the last two stages agree
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      csSync_r <= 3'h7;
      clkSync_r <= 3'h0;
      csLvl_r <= 1'b1;
      sclkLvl_r <= 1'b0;
    end
    else
    begin
      csSync_r <= {csSync_r[1:0], link.sharedRxSelectPin};
      clkSync_r <= {clkSync_r[1:0], link.spiClk};
      if (csSync_r[1] == csSync_r[2])
        csLvl_r <= csSync_r[2];
      if (clkSync_r[1] == clkSync_r[2])
        sclkLvl_r <= clkSync_r[2];
    end
  end

  wire logic csNow = pinIsCs & ~csLvl_r;
  wire logic sclkRise = (clkSync_r[2] == clkSync_r[1]) & clkSync_r[2] & ~sclkLvl_r;
  wire logic sclkFall = (clkSync_r[2] == clkSync_r[1]) & ~clkSync_r[2] & sclkLvl_r;
  wire logic spiLast = spiFromFrame_r & (spiIdx_r == frameLen_r - 5'h01);
  wire logic crcDone = (txState_r == TX_CRC) & (byteIdx_r == payEnd);

  // spi slave, mode 0: shift on falling edge, master samples on rising
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      csActive_r <= 1'b0;
      spiBit_r <= 3'h0;
      spiIdx_r <= 5'h00;
      spiFromFrame_r <= 1'b0;
      spiShift_r <= `LPS_SPI_FILLER;
      misoOe_r <= 1'b0;
      pending_r <= 1'b0;
    end
    else
    begin
      csActive_r <= csNow;
      misoOe_r <= csNow;
      if (crcDone)
        pending_r <= 1'b1;
      else if (csActive_r && sclkFall && spiBit_r == 3'h0 && spiLast)
        pending_r <= 1'b0;
      if (csNow && !csActive_r)
      begin
        spiBit_r <= 3'h0;
        spiIdx_r <= 5'h00;
        spiFromFrame_r <= pending_r & ~crcDone & (txState_r != TX_CRC);
        spiShift_r <= (pending_r && txState_r != TX_CRC) ? frame_r[0] : `LPS_SPI_FILLER;
      end
      else if (csActive_r && sclkRise)
        spiBit_r <= spiBit_r + 3'h1;
      else if (csActive_r && sclkFall)
      begin
        if (spiBit_r == 3'h0)
        begin
          if (spiFromFrame_r && !spiLast)
          begin
            spiIdx_r <= spiIdx_r + 5'h01;
            spiShift_r <= frame_r[spiIdx_r+5'h01];
          end
          else
          begin
            spiFromFrame_r <= 1'b0;
            spiShift_r <= `LPS_SPI_FILLER;
          end
        end
        else
          spiShift_r <= {spiShift_r[6:0], 1'b0};
      end
    end
  end

  // ready while neither serial nor spi holds the frame store
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      ready_r <= 1'b0;
    else
      ready_r <= (txState_r == TX_IDLE) & ~latch & ~csNow & ~csActive_r;
  end

  assign link.serialOutLine = txLine_r;
  assign link.spiMiso = spiShift_r[7];
  assign link.spiMisoOe = misoOe_r;
  assign measReady = ready_r;
  assign spiFramePending = pending_r;
endmodule

/* File: verilog/lps_host.sv */
`timescale 1ns/1ps
`include "lps_map.svh"
module lps_host
  import lps_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  lps_link_if.master       link,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata
);
  import lps_pkg::*;

  logic         csAssert_r;
  lps_baud_type baud_r;
  logic [7:0]   sckCnt_r;
  logic [4:0]   edgeCnt_r;
  logic         sck_r;
  logic [7:0]   spiRx_r;
  logic [2:0]   rxSync_r;
  logic         rxLvl_r;
  logic         rxBusy_r;
  logic [15:0]  rxCnt_r;
  logic [3:0]   rxBit_r;
  logic [7:0]   rxShift_r;
  logic [7:0]   rxData_r;
  logic         rxValid_r;
  logic         rxErr_r;
  logic [31:0]  rdata_r;

  wire logic        spiBusy = (edgeCnt_r != 5'h00);
  wire logic        sckTick = spiBusy & (sckCnt_r == `LPS_SCK_HALF - 8'h01);
  wire logic [15:0] div = lps_baud_div(baud_r);
  wire logic        rxTick = rxBusy_r & (rxCnt_r == div - 16'h0001);
  wire logic        rxStartSeen = ~rxBusy_r & ~rxLvl_r;
  wire logic        wrCtrl = regWr & (regAddr == `LPS_REG_CTRL);
  wire logic        wrSpi = regWr & (regAddr == `LPS_REG_SPIDATA) & csAssert_r & ~spiBusy;
  wire logic        rdRx = regRd & (regAddr == `LPS_REG_RXDATA);
  wire logic [31:0] rdMux =
    (regAddr == `LPS_REG_CTRL)    ? {28'h0, baud_r, csAssert_r} :
    (regAddr == `LPS_REG_SPIDATA) ? {24'h0, spiRx_r} :
    (regAddr == `LPS_REG_STATUS)  ? {29'h0, rxErr_r, rxValid_r, spiBusy} :
    (regAddr == `LPS_REG_RXDATA)  ? {24'h0, rxData_r} : 32'h0000_0000;

  // control register and read port
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      csAssert_r <= 1'b0;
      baud_r <= LPS_B500K;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (wrCtrl)
      begin
        csAssert_r <= regWdata[`LPS_CTRL_CS];
        baud_r <= lps_baud_type'(regWdata[`LPS_CTRL_BAUD_LO +: 3]);
      end
      rdata_r <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  // spi master, mode 0: 16 half periods per byte, sample on rising edge
  // eight-cycle halves leave room for the slave's pin synchronisers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sckCnt_r <= 8'h00;
      edgeCnt_r <= 5'h00;
      sck_r <= 1'b0;
      spiRx_r <= 8'h00;
    end
    else
    begin
      if (wrSpi)
      begin
        edgeCnt_r <= 5'h10;
        sckCnt_r <= 8'h00;
      end
      else if (sckTick)
      begin
        sckCnt_r <= 8'h00;
        edgeCnt_r <= edgeCnt_r - 5'h01;
        sck_r <= ~sck_r;
        if (!sck_r)
          spiRx_r <= {spiRx_r[6:0], link.spiMiso};
      end
      else if (spiBusy)
        sckCnt_r <= sckCnt_r + 8'h01;
    end
  end

  // 8N1 receiver on the beacon serial line, mid-bit sampling
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rxSync_r <= 3'h7;
      rxLvl_r <= 1'b1;
      rxBusy_r <= 1'b0;
      rxCnt_r <= 16'h0000;
      rxBit_r <= 4'h0;
      rxShift_r <= 8'h00;
      rxData_r <= 8'h00;
      rxValid_r <= 1'b0;
      rxErr_r <= 1'b0;
    end
    else
    begin
      rxSync_r <= {rxSync_r[1:0], link.serialOutLine};
      if (rxSync_r[1] == rxSync_r[2])
        rxLvl_r <= rxSync_r[2];
      if (rxStartSeen)
      begin
        rxBusy_r <= 1'b1;
        rxCnt_r <= div >> 1;
        rxBit_r <= 4'h0;
      end
      else if (rxTick)
      begin
        rxCnt_r <= 16'h0000;
        rxBit_r <= rxBit_r + 4'h1;
        if (rxBit_r == 4'h9)
        begin
          rxBusy_r <= 1'b0;
          rxData_r <= rxShift_r;
          rxErr_r <= ~rxLvl_r;
        end
        else if (rxBit_r != 4'h0)
          rxShift_r <= {rxLvl_r, rxShift_r[7:1]};
      end
      else if (rxBusy_r)
        rxCnt_r <= rxCnt_r + 16'h0001;
      if (rxTick && rxBit_r == 4'h9)
        rxValid_r <= 1'b1;
      else if (rdRx)
        rxValid_r <= 1'b0;
    end
  end

  assign link.sharedRxSelectPin = ~csAssert_r;
  assign link.spiClk = sck_r;
  assign regRdata = rdata_r;
endmodule

/* File: testbench/lps_link_props.sv */
`timescale 1ns/1ps
module lps_link_props (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serialOutLine,
  input wire logic sharedRxSelectPin,
  input wire logic spiClk,
  input wire logic spiMiso,
  input wire logic spiMisoOe
);
  logic [15:0] runLen_r;
  logic        lastLine_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // cycles spent at the present serial line level, saturating
  always_ff @(posedge clk_sys)
  begin
    lastLine_r <= serialOutLine;
    if (!reset_n || serialOutLine != lastLine_r)
      runLen_r <= 16'h0001;
    else if (runLen_r != 16'hFFFF)
      runLen_r <= runLen_r + 16'h0001;
  end

  // serial line and spi data pin as the port comes out of reset
  a_reset_idle_line: assert property (disable iff (1'b0) !reset_n |=> serialOutLine && !spiMisoOe)
    else $error("serial line low or miso driven after reset");
  // low runs are whole bits: 40 cycles at the fastest rate, at most 9 bits at the slowest
  a_bit_length: assert property (serialOutLine && !lastLine_r |-> runLen_r inside {[16'h0028:16'h9276]})
    else $error("serial low run not a whole number of bits");
  // beacon stops driving miso within eight cycles of deselection
  a_oe_idle_cs: assert property (sharedRxSelectPin [*8] |-> !spiMisoOe)
    else $error("miso driven while chip select idle");
  // mode 0 clock rests low outside a selection
  a_clk_idle_low: assert property (sharedRxSelectPin |-> !spiClk)
    else $error("spi clock high while deselected");
  // chip select leads the first clock edge
  a_cs_setup_time: assert property ($fell(sharedRxSelectPin) |-> !spiClk [*5])
    else $error("spi clock too soon after select");
  // eight-cycle high half keeps the clock well under the rate limit
  a_clk_high_half: assert property ($rose(spiClk) |-> spiClk [*8] ##1 !spiClk)
    else $error("spi clock high half not eight cycles");
  a_clk_low_half: assert property ($fell(spiClk) |-> !spiClk [*8])
    else $error("spi clock low half too short");
  // deselect only with the clock at rest
  a_cs_release_low: assert property ($rose(sharedRxSelectPin) |-> !$past(spiClk))
    else $error("chip select released with clock high");
  // miso settled while the clock is high
  a_miso_hold_high: assert property (spiClk [*3] |-> $stable(spiMiso))
    else $error("miso changed while spi clock high");
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import lps_pkg::*;
  logic               clk_sys, reset_n, measStrobe, measValid, mmMode, tsMillis, btnFirst;
  logic               btnSecond, uploadPending, downloadWanted, otherBeacon, pinIsCs;
  logic               cfgBaudWr, measReady, spiFramePending, regWr, regRd;
  logic [31:0]        timeStamp, regWdata, regRdata, rd;
  logic signed [31:0] posX, posY, posZ;
  logic [7:0]         beaconAddr, rxByte, b;
  logic [11:0]        heading;
  logic [15:0]        elapsedMs;
  logic [3:0]         regAddr;
  lps_baud_type       cfgBaud;
  logic [7:0]         expQ[$], rxQ[$];
  int                 bitDiv, mismatches, compares, cycles;

  lps_link_if link();
  lps_beacon lps_beacon_i (
    .clk_sys, .reset_n, .link(link), .measStrobe, .measValid, .mmMode, .timeStamp, .tsMillis,
    .posX, .posY, .posZ, .btnFirst, .btnSecond, .uploadPending, .downloadWanted, .otherBeacon,
    .beaconAddr, .heading, .elapsedMs, .pinIsCs, .cfgBaud, .cfgBaudWr, .measReady,
    .spiFramePending
  );
  lps_host lps_host_i (
    .clk_sys, .reset_n, .link(link), .regAddr, .regWdata, .regWr, .regRd, .regRdata
  );
  lps_link_props lps_link_props_i (
    .clk_sys, .reset_n, .serialOutLine(link.serialOutLine),
    .sharedRxSelectPin(link.sharedRxSelectPin), .spiClk(link.spiClk), .spiMiso(link.spiMiso),
    .spiMisoOe(link.spiMisoOe)
  );

  // system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, well above the three frames at their rates
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      conclude();
    end
  end

  // receiver on the line itself: start, eight bits lsb first, stop
  always
  begin
    @(negedge link.serialOutLine);
    repeat (bitDiv / 2) @(posedge clk_sys);
    check(link.serialOutLine, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bitDiv) @(posedge clk_sys);
      rxByte[i] = link.serialOutLine;
    end
    repeat (bitDiv) @(posedge clk_sys);
    check(link.serialOutLine, 1'b1);
    rxQ.push_back(rxByte);
  end

  // bounded wait for measReady (sel high) or spiFramePending
  task automatic waitBit(input logic sel, input int lim);
    int n;
    n = 0;
    while ((sel ? measReady : spiFramePending) !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(sel ? measReady : spiFramePending, 1'b1);
  endtask

  // register write and read; read data stand in the cycle after the strobe
  task automatic regW(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic regR(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask

  // one spi byte: start, poll busy, fetch
  task automatic spiByte();
    int n;
    n = 0;
    regW(4'h4, 32'h0000_0000);
    do
    begin
      regR(4'h8);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 100);
    regR(4'h4);
    b = rd[7:0];
  endtask

  // reference frame: header, payload low byte first, crc low byte first
  task automatic buildFrame();
    logic [15:0] crc;
    int          w;
    w = mmMode ? 4 : 2;
    expQ = {8'hFF, 8'h47, mmMode ? 8'h11 : 8'h01, 8'h00, mmMode ? 8'h16 : 8'h10};
    for (int i = 0; i < 4; i++)
      expQ.push_back(timeStamp[8*i +: 8]);
    for (int i = 0; i < 3 * w; i++)
      expQ.push_back(8'({posZ, posY, posX} >> (32 * (i / w) + 8 * (i % w))));
    expQ.push_back({1'b0, otherBeacon, btnSecond, downloadWanted, uploadPending, btnFirst,
                    tsMillis, !measValid});
    expQ.push_back(beaconAddr);
    expQ.push_back(heading[7:0]);
    expQ.push_back({4'h0, heading[11:8]});
    expQ.push_back(elapsedMs[7:0]);
    expQ.push_back(elapsedMs[15:8]);
    crc = 16'hFFFF;
    foreach (expQ[i])
    begin
      crc = crc ^ {expQ[i], 8'h00};
      for (int k = 0; k < 8; k++)
        crc = crc[15] ? ((crc << 1) ^ 16'h8005) : (crc << 1);
    end
    expQ.push_back(crc[7:0]);
    expQ.push_back(crc[15:8]);
  endtask

  // one measurement with a refused repeat strobe, spi readout, serial compare
  task automatic runFrame(input logic mm, input logic [6:0] fl, input logic [31:0] x,
                          input logic spi);
    @(posedge clk_sys);
    mmMode <= mm;
    pinIsCs <= spi;
    {otherBeacon, btnSecond, downloadWanted, uploadPending, btnFirst, tsMillis, measValid} <= fl;
    posX <= x;
    posY <= ~x;
    posZ <= x ^ 32'h00FF_0F0F;
    timeStamp <= {x[15:0], x[31:16]};
    beaconAddr <= x[31:24];
    heading <= 12'hE10;
    elapsedMs <= x[23:8];
    measStrobe <= 1'b1;
    @(posedge clk_sys);
    measStrobe <= 1'b0;
    #1 buildFrame();
    rxQ.delete();
    @(posedge clk_sys);
    measStrobe <= 1'b1;
    @(posedge clk_sys);
    measStrobe <= 1'b0;
    #1 check(measReady, 1'b0);
    waitBit(1'b0, 100);
    regW(4'h0, 32'h0000_000D);
    repeat (8) @(posedge clk_sys);
    if (spi)
    begin
      foreach (expQ[i])
      begin
        spiByte();
        check(b, expQ[i]);
      end
    end
    spiByte();
    if (spi) check(b, 8'h00);
    check(spiFramePending, !spi);
    regW(4'h0, 32'h0000_000C);
    waitBit(1'b1, 60000);
    repeat (500) @(posedge clk_sys);
    check(rxQ.size(), expQ.size());
    foreach (expQ[i])
      check(rxQ[i], expQ[i]);
    $display("frame test done: code %h, %0d bytes", expQ[2], expQ.size());
  endtask

  // reset, then cm frame at reset rate, mm frame, cm frame at 115.2 kbps with spi off
  initial
  begin
    {measStrobe, measValid, mmMode, tsMillis, btnFirst, btnSecond, uploadPending} = '0;
    {downloadWanted, otherBeacon, cfgBaudWr, regWr, regRd, reset_n} = '0;
    {timeStamp, posX, posY, posZ, regWdata} = '0;
    {beaconAddr, heading, elapsedMs, regAddr} = '0;
    pinIsCs = 1'b1;
    cfgBaud = LPS_B500K;
    bitDiv = 20000000 / 500000;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    waitBit(1'b1, 10);
    runFrame(1'b0, 7'h46, 32'h8001_FF38, 1'b1);
    regR(4'h8);
    check(rd[2:1], 2'b01);
    regR(4'hC);
    check(rd[7:0], expQ[$]);
    regR(4'h1);
    check(rd, 32'h0000_0000);
    runFrame(1'b1, 7'h39, 32'hFFFE_1234, 1'b1);
    @(posedge clk_sys);
    cfgBaud <= LPS_B115K2;
    cfgBaudWr <= 1'b1;
    @(posedge clk_sys);
    cfgBaudWr <= 1'b0;
    bitDiv = 20000000 / 115200;
    runFrame(1'b0, 7'h03, 32'h0123_4567, 1'b0);
    conclude();
  end
endmodule
